// ===== logic/pmm_core.sv
// Program counter, vectoring and program memory mode selection for the core.
// Notes on behaviour
// - Program and data memory use separate buses, both usable in one cycle.
// - Program counter is 16 bits, addressing 64K words of 16 bits.
// - Reset loads program counter with zero and fetching starts there.
// - Interrupt vectors sit at 0x0008, 0x0010, 0x0018 and 0x0020.
// - Two configuration bits choose one of four program memory modes.
// - Microcontroller and protected modes fetch only on chip, never externally.
// - Internal-only reads beyond on-chip memory return undefined data, with an error only in a region the mode denies.
// - Protected mode also turns on code protection of on-chip memory.
// - Extended mode picks internal or external memory by address automatically.
// - Extended and microprocessor modes drive all 16 address bits externally.
// - Microprocessor mode fetches everything externally, ignoring on-chip memory.
// - Unprogrammed configuration bits give microprocessor mode.
// - Mode decides access to configuration, test and boot regions.
`timescale 1ns/1ps
`default_nettype none
module pmm_core
    import pmm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [1:0]        mode_cfg,
    input  wire logic              fetch_step,
    input  wire logic              branch_en,
    input  wire logic [PC_W-1:0]   branch_addr,
    input  wire logic              irq_take,
    input  wire logic [1:0]        irq_group,
    output pmm_ext_fetch_s         ext_fetch,
    input  wire logic [WORD_W-1:0] ext_rdata,
    input  wire logic              prog_we,
    input  wire logic [INT_AW-1:0] prog_addr,
    input  wire logic [WORD_W-1:0] prog_wdata,
    input  wire logic [PC_W-1:0]   verify_addr,
    output logic      [WORD_W-1:0] verify_data,
    input  wire pmm_data_req_s     data_in,
    output pmm_data_req_s          data_out,
    output logic      [PC_W-1:0]   pc,
    output logic      [WORD_W-1:0] instr,
    output logic                   instr_valid,
    output logic                   region_fault,
    output logic                   code_protect,
    output pmm_mode_e              mode
);

    function automatic pmm_mode_e decode_mode(input logic [1:0] cfg);
        case (cfg)
            CFG_MC:  decode_mode = PMM_MODE_MC;
            CFG_EMC: decode_mode = PMM_MODE_EMC;
            CFG_PMC: decode_mode = PMM_MODE_PMC;
            default: decode_mode = PMM_MODE_MP;
        endcase
    endfunction

    function automatic logic on_chip(input logic [PC_W-1:0] a);
        on_chip = (a <= INT_LAST);
    endfunction

    // Special regions that a mode may refuse; microprocessor mode allows all.
    function automatic logic region_denied(input pmm_mode_e m, input logic [PC_W-1:0] a);
        logic special;
        special = (a >= CFG_LO);
        case (m)
            PMM_MODE_MP:  region_denied = 1'b0;
            PMM_MODE_MC:  region_denied = (a >= TEST_LO) && (a <= TEST_HI);
            PMM_MODE_EMC: region_denied = special;
            PMM_MODE_PMC: region_denied = special;
            default:      region_denied = special;
        endcase
    endfunction

    // Mode is latched once, at the first edge after reset release.
    pmm_mode_e         mode_q, mode_d;
    logic              cfg_seen_q, cfg_seen_d;
    logic [PC_W-1:0]   pc_q, pc_d;
    logic [WORD_W-1:0] instr_q, instr_d;
    logic              valid_q, valid_d;
    logic              fault_q, fault_d;
    logic [WORD_W-1:0] verify_q, verify_d;
    pmm_data_req_s     data_q, data_d;
    logic [WORD_W-1:0] int_rdata;
    logic [WORD_W-1:0] int_vdata;
    logic              use_ext;
    logic              int_fetch_ok;
    logic              protect;
    logic [INT_AW-1:0] int_rd_addr;
    logic              fetching;

    always_comb begin
        cfg_seen_d = 1'b1;
        mode_d     = cfg_seen_q ? mode_q : decode_mode(mode_cfg);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_seen_q <= 1'b0;
            mode_q     <= PMM_MODE_MP;
        end else begin
            cfg_seen_q <= cfg_seen_d;
            mode_q     <= mode_d;
        end
    end

    assign protect  = (mode_q == PMM_MODE_PMC);
    assign fetching = cfg_seen_q && fetch_step;

    // Fetch routing by mode and by address.
    always_comb begin
        case (mode_q)
            PMM_MODE_MP:  use_ext = 1'b1;
            PMM_MODE_EMC: use_ext = !on_chip(pc_q);
            PMM_MODE_MC:  use_ext = 1'b0;
            PMM_MODE_PMC: use_ext = 1'b0;
            default:      use_ext = 1'b1;
        endcase
    end

    assign int_fetch_ok = on_chip(pc_q);
    assign int_rd_addr  = pc_q[INT_AW-1:0];

    // The full 16-bit address goes out only when the fetch is external.
    always_comb begin
        ext_fetch.rd   = fetching && use_ext && !region_denied(mode_q, pc_q);
        ext_fetch.addr = ext_fetch.rd ? pc_q : 16'h0000;
    end

    always_comb begin
        pc_d     = pc_q;
        instr_d  = instr_q;
        valid_d  = 1'b0;
        fault_d  = 1'b0;
        if (fetching) begin
            valid_d = 1'b1;
            if (region_denied(mode_q, pc_q)) begin
                instr_d = UNDEF_WORD;
                fault_d = 1'b1;
            end else if (use_ext) begin
                instr_d = ext_rdata;
            end else if (int_fetch_ok) begin
                instr_d = int_rdata;
            end else begin
                instr_d = UNDEF_WORD;
            end
        end
        if (irq_take) begin
            pc_d = PC_W'(VEC_STEP * ({14'h0000, irq_group} + 16'h0001));
        end else if (branch_en) begin
            pc_d = branch_addr;
        end else if (fetching) begin
            pc_d = PC_W'(pc_q + 16'h0001);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q    <= RESET_VEC;
            instr_q <= 16'h0000;
            valid_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            pc_q    <= pc_d;
            instr_q <= instr_d;
            valid_q <= valid_d;
            fault_q <= fault_d;
        end
    end

    // Verify reads of on-chip memory are blanked when protected.
    always_comb begin
        if (protect) begin
            verify_d = PROT_WORD;
        end else if (on_chip(verify_addr)) begin
            verify_d = int_vdata;
        end else begin
            verify_d = UNDEF_WORD;
        end
    end

    // Data bus is registered independently of the fetch path.
    always_comb begin
        data_d = data_in;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            verify_q <= 16'h0000;
            data_q   <= '0;
        end else begin
            verify_q <= verify_d;
            data_q   <= data_d;
        end
    end

    pmm_int_mem u_mem (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (prog_we && !protect),
        .wr_addr (prog_addr),
        .wr_data (prog_wdata),
        .rd_addr (int_rd_addr),
        .rd_data (int_rdata)
    );

    // Second read port for verification is a duplicate array written in parallel with the first.
    pmm_int_mem u_vmem (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (prog_we && !protect),
        .wr_addr (prog_addr),
        .wr_data (prog_wdata),
        .rd_addr (verify_addr[INT_AW-1:0]),
        .rd_data (int_vdata)
    );

    assign pc           = pc_q;
    assign instr        = instr_q;
    assign instr_valid  = valid_q;
    assign region_fault = fault_q;
    assign code_protect = protect;
    assign mode         = mode_q;
    assign verify_data  = verify_q;
    assign data_out     = data_q;

endmodule
`default_nettype wire

// ===== pkg/pmm_pkg.sv
// Constants and types for the program memory mode map.
package pmm_pkg;

    localparam int          PC_W        = 16;
    localparam int          WORD_W      = 16;
    localparam int          INT_AW      = 8;
    localparam int          INT_DEPTH   = 256;
    localparam logic [15:0] INT_LAST    = 16'h00ff;
    localparam logic [15:0] RESET_VEC   = 16'h0000;
    localparam logic [15:0] VEC_STEP    = 16'h0008;
    localparam logic [15:0] CFG_LO      = 16'hfe00;
    localparam logic [15:0] CFG_HI      = 16'hfe0f;
    localparam logic [15:0] TEST_LO     = 16'hfe10;
    localparam logic [15:0] TEST_HI     = 16'hff5f;
    localparam logic [15:0] BOOT_LO     = 16'hff60;
    localparam logic [15:0] UNDEF_WORD  = 16'hffff;
    localparam logic [15:0] PROT_WORD   = 16'h0000;

    localparam logic [1:0]  CFG_MP      = 2'h3;
    localparam logic [1:0]  CFG_MC      = 2'h2;
    localparam logic [1:0]  CFG_EMC     = 2'h1;
    localparam logic [1:0]  CFG_PMC     = 2'h0;

    typedef enum logic [3:0] {
        PMM_MODE_MP  = 4'b0001,
        PMM_MODE_MC  = 4'b0010,
        PMM_MODE_EMC = 4'b0100,
        PMM_MODE_PMC = 4'b1000
    } pmm_mode_e;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } pmm_ext_fetch_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } pmm_data_req_s;

endpackage

// ===== logic/pmm_int_mem.sv
// On-chip program memory held in flip-flops, with a programming write port.
`timescale 1ns/1ps
`default_nettype none
module pmm_int_mem
    import pmm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              wr_en,
    input  wire logic [INT_AW-1:0] wr_addr,
    input  wire logic [WORD_W-1:0] wr_data,
    input  wire logic [INT_AW-1:0] rd_addr,
    output logic      [WORD_W-1:0] rd_data
);

    logic [WORD_W-1:0] mem_q [INT_DEPTH];
    logic [WORD_W-1:0] mem_d [INT_DEPTH];

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < INT_DEPTH; i++) begin
                mem_q[i] <= UNDEF_WORD;
            end
        end else begin
            mem_q <= mem_d;
        end
    end

    assign rd_data = mem_q[rd_addr];

endmodule
`default_nettype wire

// ===== test/pmm_ext_mem.sv
// External program memory model on the fetch bus.
`timescale 1ns/1ps
`default_nettype none
module pmm_ext_mem
    import pmm_pkg::*;
(
    input  wire logic           clk,
    input  wire pmm_ext_fetch_s ext_fetch,
    output logic [15:0]         ext_rdata
);
    logic [15:0] last_q = 16'h0000;
    // Without a strobe the bus shows the inverse of the last word, so a stale sample shows up.
    always_ff @(posedge clk) begin
        if (ext_fetch.rd) begin
            last_q <= ext_fetch.addr ^ 16'h5a5a;
        end
    end
    assign ext_rdata = ext_fetch.rd ? (ext_fetch.addr ^ 16'h5a5a) : ~last_q;
endmodule
`default_nettype wire

// ===== test/pmm_core_chk.sv
// Concurrent checks on the ports of the program memory core.
`timescale 1ns/1ps
`default_nettype none
module pmm_core_chk
    import pmm_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst_b,
    input wire logic           fetch_step,
    input wire logic           branch_en,
    input wire logic [15:0]    branch_addr,
    input wire logic           irq_take,
    input wire logic [1:0]     irq_group,
    input wire pmm_ext_fetch_s ext_fetch,
    input wire logic [15:0]    pc,
    input wire logic [15:0]    instr,
    input wire logic           instr_valid,
    input wire logic           region_fault,
    input wire logic           code_protect,
    input wire pmm_mode_e      mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_fetch;
        fetch_step && $past(rst_b);
    endsequence
    a_reset_vector: assert property ($rose(rst_b) |-> pc == RESET_VEC)
        else $error("pc not at reset vector");
    a_irq_vector: assert property (irq_take |=>
        pc == VEC_STEP * (16'($past(irq_group)) + 16'h1)) else $error("bad vector");
    a_branch_load: assert property (branch_en && !irq_take |=> pc == $past(branch_addr))
        else $error("branch not loaded");
    a_internal_only: assert property (mode inside {PMM_MODE_MC, PMM_MODE_PMC}
        |-> !ext_fetch.rd) else $error("external fetch in internal mode");
    a_mp_external: assert property (s_fetch and mode == PMM_MODE_MP
        |-> ext_fetch.rd && ext_fetch.addr == pc) else $error("fetch not external");
    a_protect_flag: assert property (code_protect == (mode == PMM_MODE_PMC))
        else $error("protect flag wrong");
    a_fetch_valid: assert property (s_fetch |=> instr_valid)
        else $error("no valid after fetch");
    a_ext_split: assert property (s_fetch and mode == PMM_MODE_EMC
        |-> ext_fetch.rd == (pc > INT_LAST && pc < CFG_LO)) else $error("bad split");
    a_test_denied: assert property (s_fetch and mode != PMM_MODE_MP && pc >= TEST_LO
        && pc <= TEST_HI |=> region_fault && instr == UNDEF_WORD) else $error("test open");
    a_undef_word: assert property (s_fetch and mode == PMM_MODE_MC && pc > INT_LAST
        && pc < CFG_LO |=> instr == UNDEF_WORD && !region_fault) else $error("not undef");
endmodule
bind pmm_core pmm_core_chk u_chk (.clk, .rst_b, .fetch_step, .branch_en, .branch_addr,
    .irq_take, .irq_group, .ext_fetch, .pc, .instr, .instr_valid, .region_fault,
    .code_protect, .mode);
`default_nettype wire

// ===== test/tb_program_memory_mode_map.sv
// Self-checking bench for the program memory mode core.
`timescale 1ns/1ps
`default_nettype none
module tb_program_memory_mode_map;
    import pmm_pkg::*;
    logic clk = 0, rst_b = 0, fetch_step = 0, branch_en = 0, irq_take = 0, prog_we = 0;
    logic [1:0] mode_cfg = CFG_MP, irq_group = 2'h0;
    logic [15:0] branch_addr = 16'h0, prog_wdata = 16'h0, verify_addr = 16'h0;
    logic [7:0] prog_addr = 8'h0;
    logic [15:0] ext_rdata, verify_data, pc, instr;
    logic instr_valid, region_fault, code_protect;
    pmm_ext_fetch_s ext_fetch;
    pmm_data_req_s data_in = '0, data_out;
    pmm_mode_e mode;
    int bad_count = 0, total_checks = 0;
    pmm_core u_dut (.clk, .rst_b, .mode_cfg, .fetch_step, .branch_en, .branch_addr,
        .irq_take, .irq_group, .ext_fetch, .ext_rdata, .prog_we, .prog_addr, .prog_wdata,
        .verify_addr, .verify_data, .data_in, .data_out, .pc, .instr, .instr_valid,
        .region_fault, .code_protect, .mode);
    pmm_ext_mem u_mem (.clk, .ext_fetch, .ext_rdata);
    initial forever #2.5 clk = ~clk;
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        end_sim;
    end
    task do_rst(input logic [1:0] c);
        rst_b = 0;
        mode_cfg = c;
        repeat (5) @(posedge clk);
        #1 rst_b = 1;
        @(posedge clk);
        #1 chk(pc === RESET_VEC, "reset pc");
    endtask
    // Branches to a, fetches once with a data access in the same cycle.
    task fetch(input logic [15:0] a, input logic x, input logic f, input logic [15:0] e);
        branch_addr = a;
        branch_en = 1;
        @(posedge clk);
        #1 branch_en = 0;
        fetch_step = 1;
        data_in = {2'b11, a[7:0], 8'h3c};
        #1 chk(ext_fetch.rd === x && ext_fetch.addr === (x ? a : 16'h0000), "ext strobe");
        @(posedge clk);
        #1 fetch_step = 0;
        chk(instr_valid === 1'b1 && instr === e && region_fault === f, "fetch word");
        chk(data_out === {2'b11, a[7:0], 8'h3c}, "data bus");
    endtask
    task scen_mode(input logic [1:0] c);
        logic mp, ext;
        mp = (c == CFG_MP);
        ext = mp || (c == CFG_EMC);
        do_rst(c);
        chk(mode === pmm_mode_e'(4'h1 << (2'h3 - c)), "mode");
        chk(code_protect === (c == CFG_PMC), "protect");
        prog_we = 1;
        prog_addr = 8'h05;
        prog_wdata = 16'h1234;
        // The mode is latched after reset, so this change must not take effect.
        mode_cfg = ~c;
        @(posedge clk);
        #1 prog_we = 0;
        verify_addr = 16'h0005;
        @(posedge clk);
        #1 chk(verify_data === (c == CFG_PMC ? PROT_WORD : 16'h1234), "verify");
        verify_addr = 16'h0100;
        @(posedge clk);
        #1 chk(verify_data === (c == CFG_PMC ? PROT_WORD : UNDEF_WORD), "verify high");
        if (c != CFG_PMC) fetch(16'h0005, mp, 0, mp ? 16'h5a5f : 16'h1234);
        else fetch(16'h0005, 1'b0, 1'b0, UNDEF_WORD);
        fetch(16'h0100, ext, 0, ext ? 16'h5b5a : UNDEF_WORD);
        fetch(TEST_LO, mp, !mp, mp ? 16'ha44a : UNDEF_WORD);
        chk(mode === pmm_mode_e'(4'h1 << (2'h3 - c)), "mode held");
    endtask
    task scen_vec;
        // Branch stays requested alongside every vector load to show that the vector wins.
        irq_take = 1;
        branch_en = 1;
        for (int g = 0; g < 4; g++) begin
            irq_group = 2'(g);
            @(posedge clk);
            #1 chk(pc === 16'(8 * (g + 1)), "vector");
        end
        irq_take = 0;
        fetch(16'hffff, 1, 0, 16'ha5a5);
        chk(pc === 16'h0000, "pc wrap");
    endtask
    initial begin
        for (int c = 0; c < 4; c++) scen_mode(2'(c));
        scen_vec;
        end_sim;
    end
endmodule
`default_nettype wire
